// *** addr_cmd_pkg.sv ***
package addr_cmd_pkg;

	// ****************************************
	// command opcodes and field layout
	// ****************************************
	localparam logic [7:0] CMD_COL_LO_BASE = 8'h00; // 00h..0fh
	localparam logic [7:0] CMD_COL_HI_BASE = 8'h10; // 10h..17h
	localparam logic [7:0] CMD_SET_MODE = 8'h20;
	localparam logic [7:0] CMD_LINE_WIN = 8'h21;
	localparam logic [7:0] CMD_PAGE_WIN = 8'h22;
	localparam logic [4:0] COL_HI_PREFIX = 5'h02; // top five bits of 10h..17h
	localparam logic [3:0] COL_LO_PREFIX = 4'h0; // top four bits of 00h..0fh
	localparam int MODE_SEL_BIT = 3; // parameter bit 3 of the mode byte
	localparam logic [1:0] MODE_FIELD_H = 2'h1; // bits 1:0 = 01b
	localparam logic [1:0] MODE_FIELD_PAGE = 2'h2; // bits 1:0 = 10b

	// ****************************************
	// widths and reset values
	// ****************************************
	localparam int LINE_W = 7;
	localparam int PAGE_W = 4;
	localparam logic [3:0] COL_LO_RESET = 4'h0;
	localparam logic [2:0] COL_HI_RESET = 3'h0;
	localparam logic [6:0] LINE_START_RESET = 7'h00;
	localparam logic [6:0] LINE_END_COM_RESET = 7'h7f; // last row 127
	localparam logic [6:0] LINE_END_SEG_RESET = 7'h3f; // last column 63
	localparam logic [3:0] PAGE_START_RESET = 4'h0;
	localparam logic [3:0] PAGE_END_COM_RESET = 4'h7;
	localparam logic [3:0] PAGE_END_SEG_RESET = 4'hf;

	// ****************************************
	// frame timing
	// ****************************************
	localparam int CLK_HZ = 200_000_000;
	localparam int OSC_HZ = 688_000; // typical oscillator rate
	localparam int OSC_DIV = CLK_HZ / OSC_HZ; // system clocks per oscillator cycle
	localparam int DIV_RATIO = 1;
	localparam int ROW_CLOCKS = 103;
	localparam int ROWS_PER_FRAME = 64;

	// ****************************************
	// types
	// ****************************************
	typedef enum logic [1:0] {
		MODE_COM_H = 2'b00,
		MODE_PAGE = 2'b01,
		MODE_SEG_H = 2'b10
	} addr_mode_t;

	typedef enum logic [1:0] {
		ST_OPCODE = 2'b00,
		ST_MODE_ARG = 2'b01,
		ST_START_ARG = 2'b10,
		ST_END_ARG = 2'b11
	} dec_state_t;

	typedef struct packed {
		logic [LINE_W-1:0] start_addr;
		logic [LINE_W-1:0] end_addr;
	} line_win_t;

	typedef struct packed {
		logic [PAGE_W-1:0] start_addr;
		logic [PAGE_W-1:0] end_addr;
	} page_win_t;

	typedef struct packed {
		logic [3:0] lo;
		logic [2:0] hi;
	} col_start_t;

endpackage : addr_cmd_pkg

// *** display_addr_cmd_decoder.sv ***
`timescale 1ns/1ps

// Notes on behaviour
// - opcode 00h-0fh loads bits 3:0 into the column start low nibble
// - opcode 10h-17h loads bits 2:0 into the column start high nibble
// - both column start nibbles are zero after reset
// - column nibble opcodes act only in banked page mode
// - opcode 20h plus one byte picks common, page or segment horizontal mode
// - opcode 21h takes start then end byte, seven bits each
// - common horizontal mode: rows 0-127, reset 0 and 127
// - segment horizontal mode: columns 0-63, reset 0 and 63
// - line window applies only in the two horizontal modes
// - column counts along common direction, row along segment direction
// - opcode 22h sets page window start and end for horizontal modes
// - common horizontal mode: pages 0-7, reset 0 and 7
// - segment horizontal mode: pages 0-15, reset 0 and 15
// - one frame every divide ratio times row clocks times 64 oscillator cycles
// - default row period 103 display clocks, default divide ratio 1
module display_addr_cmd_decoder #(
	parameter int OSC_DIV = addr_cmd_pkg::OSC_DIV,
	parameter int DIV_RATIO = addr_cmd_pkg::DIV_RATIO,
	parameter int ROW_CLOCKS = addr_cmd_pkg::ROW_CLOCKS,
	parameter int ROWS_PER_FRAME = addr_cmd_pkg::ROWS_PER_FRAME
) (
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_resetn,
	// host byte port
	input wire logic i_wr_strobe,
	input wire logic i_data_sel,
	input wire logic [7:0] i_byte,
	// address setup state
	output addr_cmd_pkg::col_start_t o_col_start,
	output addr_cmd_pkg::addr_mode_t o_addr_mode,
	output addr_cmd_pkg::line_win_t o_line_win,
	output addr_cmd_pkg::page_win_t o_page_win,
	output logic o_param_pending,
	// timing generator
	output logic o_display_clock_tick,
	output logic o_row_tick,
	output logic o_frame_tick
);

	// ****************************************
	// byte intake and decode helpers
	// ****************************************
	logic take;
	logic horiz;
	logic seg_mode;
	addr_cmd_pkg::dec_state_t state_ff;
	logic page_cmd_ff;
	logic line_set_ff;
	logic page_set_ff;
	addr_cmd_pkg::col_start_t col_ff;
	addr_cmd_pkg::addr_mode_t mode_ff;
	addr_cmd_pkg::line_win_t line_ff;
	addr_cmd_pkg::page_win_t page_ff;
	addr_cmd_pkg::line_win_t nxt_line;
	addr_cmd_pkg::page_win_t nxt_page;

	// only command bytes are decoded here
	assign take = i_wr_strobe && !i_data_sel;
	assign horiz = (mode_ff == addr_cmd_pkg::MODE_COM_H) || (mode_ff == addr_cmd_pkg::MODE_SEG_H);
	assign seg_mode = (mode_ff == addr_cmd_pkg::MODE_SEG_H);

	// decode a mode byte, invalid combinations give the current mode back
	function automatic addr_cmd_pkg::addr_mode_t mode_of(input logic [7:0] b, input addr_cmd_pkg::addr_mode_t cur);
		addr_cmd_pkg::addr_mode_t m;
		m = cur;
		if (!b[addr_cmd_pkg::MODE_SEL_BIT] && b[1:0] == addr_cmd_pkg::MODE_FIELD_H) begin
			m = addr_cmd_pkg::MODE_COM_H;
		end else if (!b[addr_cmd_pkg::MODE_SEL_BIT] && b[1:0] == addr_cmd_pkg::MODE_FIELD_PAGE) begin
			m = addr_cmd_pkg::MODE_PAGE;
		end else if (b[addr_cmd_pkg::MODE_SEL_BIT] && b[1:0] == addr_cmd_pkg::MODE_FIELD_H) begin
			m = addr_cmd_pkg::MODE_SEG_H;
		end
		return m;
	endfunction : mode_of

	// ****************************************
	// opcode / parameter sequencer
	// ****************************************
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			state_ff <= addr_cmd_pkg::ST_OPCODE;
			page_cmd_ff <= 1'b0;
		end else if (take) begin
			case (state_ff)
				addr_cmd_pkg::ST_OPCODE: begin
					if (i_byte == addr_cmd_pkg::CMD_SET_MODE) begin
						state_ff <= addr_cmd_pkg::ST_MODE_ARG;
					end else if (i_byte == addr_cmd_pkg::CMD_LINE_WIN || i_byte == addr_cmd_pkg::CMD_PAGE_WIN) begin
						state_ff <= addr_cmd_pkg::ST_START_ARG;
						page_cmd_ff <= (i_byte == addr_cmd_pkg::CMD_PAGE_WIN);
					end
				end
				addr_cmd_pkg::ST_MODE_ARG: state_ff <= addr_cmd_pkg::ST_OPCODE;
				addr_cmd_pkg::ST_START_ARG: state_ff <= addr_cmd_pkg::ST_END_ARG;
				addr_cmd_pkg::ST_END_ARG: state_ff <= addr_cmd_pkg::ST_OPCODE;
				default: state_ff <= addr_cmd_pkg::ST_OPCODE;
			endcase
		end
	end

	// ****************************************
	// column start nibbles
	// ****************************************
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			col_ff.lo <= addr_cmd_pkg::COL_LO_RESET;
			col_ff.hi <= addr_cmd_pkg::COL_HI_RESET;
		end else if (take && state_ff == addr_cmd_pkg::ST_OPCODE && mode_ff == addr_cmd_pkg::MODE_PAGE) begin
			if (i_byte[7:4] == addr_cmd_pkg::COL_LO_PREFIX) begin
				col_ff.lo <= i_byte[3:0];
			end else if (i_byte[7:3] == addr_cmd_pkg::COL_HI_PREFIX) begin
				col_ff.hi <= i_byte[2:0];
			end
		end
	end

	// ****************************************
	// addressing mode
	// ****************************************
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			mode_ff <= addr_cmd_pkg::MODE_PAGE;
		end else if (take && state_ff == addr_cmd_pkg::ST_MODE_ARG) begin
			mode_ff <= mode_of(i_byte, mode_ff);
		end
	end

	// ****************************************
	// line and page windows
	// ****************************************
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			line_ff.start_addr <= addr_cmd_pkg::LINE_START_RESET;
			line_ff.end_addr <= addr_cmd_pkg::LINE_END_COM_RESET;
			page_ff.start_addr <= addr_cmd_pkg::PAGE_START_RESET;
			page_ff.end_addr <= addr_cmd_pkg::PAGE_END_COM_RESET;
			line_set_ff <= 1'b0;
			page_set_ff <= 1'b0;
		end else if (take && horiz) begin
			if (state_ff == addr_cmd_pkg::ST_START_ARG && !page_cmd_ff) begin
				line_ff.start_addr <= i_byte[addr_cmd_pkg::LINE_W-1:0];
			end
			if (state_ff == addr_cmd_pkg::ST_END_ARG && !page_cmd_ff) begin
				line_ff.end_addr <= i_byte[addr_cmd_pkg::LINE_W-1:0];
				line_set_ff <= 1'b1;
			end
			if (state_ff == addr_cmd_pkg::ST_START_ARG && page_cmd_ff) begin
				page_ff.start_addr <= i_byte[addr_cmd_pkg::PAGE_W-1:0];
			end
			if (state_ff == addr_cmd_pkg::ST_END_ARG && page_cmd_ff) begin
				page_ff.end_addr <= i_byte[addr_cmd_pkg::PAGE_W-1:0];
				page_set_ff <= 1'b1;
			end
		end
	end

	// effective windows: until written, end follows the mode default
	always_comb begin
		nxt_line = line_ff;
		nxt_page = page_ff;
		if (!line_set_ff) begin
			nxt_line.end_addr = seg_mode ? addr_cmd_pkg::LINE_END_SEG_RESET : addr_cmd_pkg::LINE_END_COM_RESET;
		end
		if (!page_set_ff) begin
			nxt_page.end_addr = seg_mode ? addr_cmd_pkg::PAGE_END_SEG_RESET : addr_cmd_pkg::PAGE_END_COM_RESET;
		end
	end

	// registered outputs
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			o_col_start <= '0;
			o_addr_mode <= addr_cmd_pkg::MODE_PAGE;
			o_line_win <= {addr_cmd_pkg::LINE_START_RESET, addr_cmd_pkg::LINE_END_COM_RESET};
			o_page_win <= {addr_cmd_pkg::PAGE_START_RESET, addr_cmd_pkg::PAGE_END_COM_RESET};
			o_param_pending <= 1'b0;
		end else begin
			o_col_start <= col_ff;
			o_addr_mode <= mode_ff;
			o_line_win <= nxt_line;
			o_page_win <= nxt_page;
			o_param_pending <= (state_ff != addr_cmd_pkg::ST_OPCODE);
		end
	end

	// ****************************************
	// frame timing chain
	// ****************************************
	logic [15:0] osc_cnt_ff;
	logic [15:0] div_cnt_ff;
	logic [15:0] rowclk_cnt_ff;
	logic [15:0] row_cnt_ff;
	logic osc_tick;
	logic display_clock_tick;
	logic row_end;

	// oscillator enable, then display clock by divide ratio
	assign osc_tick = (osc_cnt_ff == 16'(OSC_DIV - 1));
	assign display_clock_tick = osc_tick && (div_cnt_ff == 16'(DIV_RATIO - 1));
	assign row_end = display_clock_tick && (rowclk_cnt_ff == 16'(ROW_CLOCKS - 1));

	// free-running counter chain, commands never touch it
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			osc_cnt_ff <= '0;
			div_cnt_ff <= '0;
			rowclk_cnt_ff <= '0;
			row_cnt_ff <= '0;
		end else begin
			osc_cnt_ff <= osc_tick ? 16'h0000 : osc_cnt_ff + 16'h0001;
			if (osc_tick) begin
				div_cnt_ff <= display_clock_tick ? 16'h0000 : div_cnt_ff + 16'h0001;
			end
			if (display_clock_tick) begin
				rowclk_cnt_ff <= row_end ? 16'h0000 : rowclk_cnt_ff + 16'h0001;
			end
			if (row_end) begin
				row_cnt_ff <= (row_cnt_ff == 16'(ROWS_PER_FRAME - 1)) ? 16'h0000 : row_cnt_ff + 16'h0001;
			end
		end
	end

	// tick outputs, one cycle each
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			o_display_clock_tick <= 1'b0;
			o_row_tick <= 1'b0;
			o_frame_tick <= 1'b0;
		end else begin
			o_display_clock_tick <= display_clock_tick;
			o_row_tick <= row_end;
			o_frame_tick <= row_end && (row_cnt_ff == 16'(ROWS_PER_FRAME - 1));
		end
	end

	// ****************************************
	// checks
	// ****************************************
	logic [31:0] osc_since_ff;
	// oscillator cycles since the last frame tick
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			osc_since_ff <= '0;
		end else if (o_frame_tick) begin
			osc_since_ff <= osc_tick ? 32'h1 : 32'h0;
		end else if (osc_tick) begin
			osc_since_ff <= osc_since_ff + 32'h1;
		end
	end
	logic seen_frame_ff;
	// first frame seen, period check starts after it
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			seen_frame_ff <= 1'b0;
		end else if (o_frame_tick) begin
			seen_frame_ff <= 1'b1;
		end
	end

	// decoder and timing assertions
	col_lo_load_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		take && state_ff == addr_cmd_pkg::ST_OPCODE && mode_ff == addr_cmd_pkg::MODE_PAGE && i_byte[7:4] == 4'h0
		|=> ##1 o_col_start.lo == $past(i_byte[3:0], 2)) else $error("low nibble not loaded");
	col_hi_load_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		take && state_ff == addr_cmd_pkg::ST_OPCODE && mode_ff == addr_cmd_pkg::MODE_PAGE && i_byte[7:3] == 5'h02
		|=> col_ff.hi == $past(i_byte[2:0])) else $error("high nibble not loaded");
	col_guard_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		take && mode_ff != addr_cmd_pkg::MODE_PAGE |=> $stable(col_ff)) else $error("column changed outside page mode");
	mode_set_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		take && state_ff == addr_cmd_pkg::ST_MODE_ARG && i_byte[3] && i_byte[1:0] == 2'h1
		|=> mode_ff == addr_cmd_pkg::MODE_SEG_H) else $error("segment mode not selected");
	mode_invalid_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		take && state_ff == addr_cmd_pkg::ST_MODE_ARG && i_byte[1:0] == 2'h3 |=> $stable(mode_ff))
		else $error("invalid mode byte changed mode");
	line_order_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		take && state_ff == addr_cmd_pkg::ST_END_ARG && !page_cmd_ff && horiz
		|=> line_ff.end_addr == $past(i_byte[6:0]) ##1 o_line_win.end_addr == line_ff.end_addr)
		else $error("line end not taken");
	line_default_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		!line_set_ff && seg_mode |=> o_line_win.end_addr == 7'h3f) else $error("segment line end default wrong");
	page_default_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		!page_set_ff && mode_ff == addr_cmd_pkg::MODE_COM_H |=> o_page_win.end_addr == 4'h7)
		else $error("common page end default wrong");
	param_return_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		take && (state_ff == addr_cmd_pkg::ST_END_ARG || state_ff == addr_cmd_pkg::ST_MODE_ARG)
		|=> state_ff == addr_cmd_pkg::ST_OPCODE ##1 !o_param_pending) else $error("decoder stuck in parameters");
	frame_period_a: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		o_frame_tick && seen_frame_ff |-> osc_since_ff == 32'(DIV_RATIO * ROW_CLOCKS * ROWS_PER_FRAME))
		else $error("frame period wrong");

	// main scenarios reached
	mode_com_c: cover property (@(posedge i_clk_sys) disable iff (!i_resetn) mode_ff == addr_cmd_pkg::MODE_COM_H);
	line_win_c: cover property (@(posedge i_clk_sys) disable iff (!i_resetn) line_set_ff && horiz);
	page_win_c: cover property (@(posedge i_clk_sys) disable iff (!i_resetn) page_set_ff && seg_mode);
	frame_c: cover property (@(posedge i_clk_sys) disable iff (!i_resetn) o_frame_tick && seen_frame_ff);

endmodule : display_addr_cmd_decoder

// *** host_byte_writer.sv ***
`timescale 1ns/1ps

// ****************************************
// host byte writer model
// ****************************************
module host_byte_writer (
	// clock
	input wire logic i_clk_sys,
	// host byte port
	output logic o_wr_strobe,
	output logic o_data_sel,
	output logic [7:0] o_byte
);
	// only the three defined mode bytes exist here
	localparam logic [7:0] MODE_BYTE [3] = '{8'h01, 8'h02, 8'h09};

	// idle port at time zero
	initial begin
		o_wr_strobe = 1'b0;
		o_data_sel = 1'b1;
		o_byte = 8'h5a;
	end

	// bytes go out back to back, one per clock
	task automatic send(input logic sel, input logic [7:0] seq[$]);
		for (int k = 0; k < seq.size(); k++) begin
			@(posedge i_clk_sys);
			#1;
			o_wr_strobe = 1'b1;
			o_data_sel = sel;
			o_byte = seq[k];
		end
		@(posedge i_clk_sys);
		#1;
		o_wr_strobe = 1'b0;
		o_data_sel = ~o_data_sel; // no stale value once released
		o_byte = ~o_byte;
	endtask : send

	// mode opcode plus one defined mode byte
	task automatic set_mode(input int idx);
		send(1'b0, '{8'h20, MODE_BYTE[idx]});
	endtask : set_mode
endmodule : host_byte_writer

// *** display_addr_cmd_decoder_bench.sv ***
`timescale 1ns/1ps

module display_addr_cmd_decoder_bench;
	// ****************************************
	// shortened timing chain
	// ****************************************
	localparam int OSC_DIV = 2;
	localparam int DIV_RATIO = 1;
	localparam int ROW_CLOCKS = 3;
	localparam int ROWS = 4;

	logic i_clk_sys = 1'b0;
	logic i_resetn = 1'b0;
	logic wr_strobe;
	logic data_sel;
	logic [7:0] byte_val;
	addr_cmd_pkg::col_start_t col_start;
	addr_cmd_pkg::addr_mode_t addr_mode;
	addr_cmd_pkg::line_win_t line_win;
	addr_cmd_pkg::page_win_t page_win;
	logic pending;
	logic clk_tick;
	logic row_tick;
	logic frame_tick;
	int err_count = 0;
	int comparisons = 0;
	int cycles = 0;
	int n;

	// clock
	always #2.5 i_clk_sys = ~i_clk_sys;

	host_byte_writer i_host_byte_writer (
		.i_clk_sys(i_clk_sys),
		.o_wr_strobe(wr_strobe),
		.o_data_sel(data_sel),
		.o_byte(byte_val)
	);

	display_addr_cmd_decoder #(
		.OSC_DIV(OSC_DIV),
		.DIV_RATIO(DIV_RATIO),
		.ROW_CLOCKS(ROW_CLOCKS),
		.ROWS_PER_FRAME(ROWS)
	) i_display_addr_cmd_decoder (
		.i_clk_sys(i_clk_sys),
		.i_resetn(i_resetn),
		.i_wr_strobe(wr_strobe),
		.i_data_sel(data_sel),
		.i_byte(byte_val),
		.o_col_start(col_start),
		.o_addr_mode(addr_mode),
		.o_line_win(line_win),
		.o_page_win(page_win),
		.o_param_pending(pending),
		.o_display_clock_tick(clk_tick),
		.o_row_tick(row_tick),
		.o_frame_tick(frame_tick)
	);

	// ****************************************
	// helpers
	// ****************************************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic settle();
		repeat (2) @(posedge i_clk_sys);
		#1;
	endtask : settle

	task automatic do_reset();
		@(posedge i_clk_sys);
		#1;
		i_resetn = 1'b0;
		repeat (10) @(posedge i_clk_sys);
		#1;
		i_resetn = 1'b1;
	endtask : do_reset

	function automatic logic pick(input int sel);
		return (sel == 0) ? clk_tick : (sel == 1) ? row_tick : frame_tick;
	endfunction : pick

	// cycles between two pulses of one tick output
	task automatic period(input int sel, output int cnt);
		int guard;
		guard = 0;
		cnt = 0;
		while (pick(sel) !== 1'b1 && guard < 400) begin
			@(posedge i_clk_sys);
			#1;
			guard++;
		end
		do begin
			@(posedge i_clk_sys);
			#1;
			cnt++;
		end while (pick(sel) !== 1'b1 && cnt < 400);
	endtask : period

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : summarize

	// hang guard
	always @(posedge i_clk_sys) begin
		cycles++;
		if (cycles == 5000) begin
			err_count++;
			summarize();
		end
	end

	// ****************************************
	// test sequence
	// ****************************************
	initial begin
		do_reset();
		check(col_start, 7'h00);
		check(addr_mode, addr_cmd_pkg::MODE_PAGE);
		check(line_win, {7'h00, 7'h7f});
		check(page_win, {4'h0, 4'h7});
		check(pending, 1'b0);
		$display("test reset_values done");
		i_host_byte_writer.send(1'b0, '{8'h0f, 8'h17});
		settle();
		check(col_start, {4'hf, 3'h7});
		i_host_byte_writer.send(1'b0, '{8'h00, 8'h10});
		i_host_byte_writer.send(1'b1, '{8'h05});
		settle();
		check(col_start, 7'h00);
		i_host_byte_writer.send(1'b0, '{8'h21, 8'h05, 8'h10, 8'h22, 8'h02, 8'h03});
		settle();
		check(line_win, {7'h00, 7'h7f});
		check(page_win, {4'h0, 4'h7});
		check(pending, 1'b0);
		$display("test page_mode done");
		i_host_byte_writer.set_mode(0);
		settle();
		check(addr_mode, addr_cmd_pkg::MODE_COM_H);
		i_host_byte_writer.send(1'b0, '{8'h03});
		settle();
		check(col_start, 7'h00);
		i_host_byte_writer.send(1'b0, '{8'h21});
		settle();
		check(pending, 1'b1);
		i_host_byte_writer.send(1'b0, '{8'h05, 8'h64});
		settle();
		check(pending, 1'b0);
		check(line_win, {7'h05, 7'h64});
		i_host_byte_writer.send(1'b0, '{8'h22, 8'h02, 8'h06});
		settle();
		check(page_win, {4'h2, 4'h6});
		$display("test common_mode done");
		do_reset();
		i_host_byte_writer.set_mode(2);
		settle();
		check(addr_mode, addr_cmd_pkg::MODE_SEG_H);
		check(line_win, {7'h00, 7'h3f});
		check(page_win, {4'h0, 4'hf});
		i_host_byte_writer.send(1'b0, '{8'h21, 8'h03, 8'h3f, 8'h22, 8'h01, 8'h0e});
		settle();
		check(line_win, {7'h03, 7'h3f});
		check(page_win, {4'h1, 4'he});
		i_host_byte_writer.set_mode(1);
		i_host_byte_writer.send(1'b0, '{8'h0a});
		settle();
		check(addr_mode, addr_cmd_pkg::MODE_PAGE);
		check(col_start, {4'ha, 3'h0});
		$display("test segment_mode done");
		period(0, n);
		check(n, OSC_DIV * DIV_RATIO);
		period(1, n);
		check(n, OSC_DIV * DIV_RATIO * ROW_CLOCKS);
		period(2, n);
		check(n, OSC_DIV * DIV_RATIO * ROW_CLOCKS * ROWS);
		$display("test frame_timing done");
		summarize();
	end
endmodule : display_addr_cmd_decoder_bench
